// File: pgx_pkg.sv
// constants and types shared by the paging unit
package pgx_pkg;
  localparam int LIN_W = 32;
  localparam int PHYS_W = 24;
  localparam int PAGE_SHIFT = 12;
  localparam int FRAME_W = 12;
  localparam int IDX_W = 10;
  localparam int TLB_WAYS = 4;
  localparam int TLB_SETS = 8;
  localparam int TLB_ENTRIES = 32;
  localparam int SET_W = 3;
  localparam int WAY_W = 2;
  localparam int TAG_W = 17;
  localparam int ERR_W = 16;
  // entry flag positions
  localparam int ENT_P = 0;
  localparam int ENT_RW = 1;
  localparam int ENT_US = 2;
  localparam int ENT_A = 5;
  localparam int ENT_D = 6;
  // error code bit positions
  localparam int ERR_P = 0;
  localparam int ERR_WR = 1;
  localparam int ERR_US = 2;
  // machine control register paging enable
  localparam int MCR_PG = 31;
  localparam logic [1:0] USER_CPL = 2'h3;
  // control register selects
  localparam logic [1:0] CTL_FAULT_ADDR = 2'h0;
  localparam logic [1:0] CTL_DIR_BASE = 2'h1;
  localparam logic [1:0] CTL_MACHINE = 2'h2;
  // reset values
  localparam logic [31:0] FAULT_ADDR_RST = 32'h0000_0000;
  localparam logic [11:0] DIR_BASE_RST = 12'h000;
  localparam logic [15:0] ERR_RST = 16'h0000;

  typedef struct packed {
    logic valid;
    logic [TAG_W-1:0] tag;
    logic [FRAME_W-1:0] frame;
    logic us;
    logic rw;
    logic dirty;
  } pgx_tlb_entry_t;

  typedef enum logic [2:0] {
    PGX_IDLE = 3'b000,
    PGX_LOOK = 3'b001,
    PGX_DIR_RD = 3'b011,
    PGX_DIR_WR = 3'b010,
    PGX_TBL_RD = 3'b110,
    PGX_TBL_WR = 3'b111,
    PGX_FILL = 3'b101
  } pgx_state_t;
endpackage

// File: pgx_paging_unit.sv
// paging unit: translation cache, two-level table walk, page protection
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (R1) fault latches full 32-bit linear address
// (R2) directory base keeps 24 bits, low 12 zero
// (R3) directory base write flushes translation cache
// (R4) linear bits 31:22 index the directory
// (R5) linear bits 21:12 index the table
// (R6) directory entry top bits give table base
// (R7) every physical address cut to 24 bits
// (R8) table entry top bits give frame base
// (R9) entry flags: D6 A5 US2 RW1 P0
// (R10) not-present entry at either level faults
// (R11) accessed set in both entries before access
// (R12) dirty set in table entry before write
// (R13) flag updates use locked read-modify-write
// (R14) only level 3 accesses are protection checked
// (R15) effective rights are the most restrictive pair
// (R16) 32-entry four-way set-associative translation cache
// (R17) hit compares upper 20 bits, forms address
// (R18) miss walks directory then table, then fills
// (R19) protection violation also faults with address
// (R20) fault saves code pointer and 16-bit code
// (R21) code bits: user, write, protection
// (R22) descriptor table accesses report supervisor
// (R23) machine control bit 31 enables paging
// (R24) error code: P bit0, W bit1, U bit2
// (R25) low 12 linear bits pass through unchanged
module pgx_paging_unit (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [pgx_pkg::LIN_W-1:0] req_lin,
  input wire logic req_write,
  input wire logic [1:0] req_cpl,
  input wire logic req_desc,
  input wire logic [31:0] req_code_ptr,
  output logic req_ready,
  output logic xlat_done,
  output logic [pgx_pkg::PHYS_W-1:0] xlat_phys,
  output logic page_fault,
  output logic [pgx_pkg::ERR_W-1:0] fault_error_code,
  output logic [31:0] saved_code_pointer,
  input wire logic ctl_wr,
  input wire logic [1:0] ctl_sel,
  input wire logic [31:0] ctl_wdata,
  output logic [31:0] ctl_rdata,
  output logic mem_req,
  output logic mem_we,
  output logic mem_lock,
  output logic [pgx_pkg::PHYS_W-1:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack
);
  import pgx_pkg::*;

  // all state of the unit, registered as one word
  typedef struct packed {
    pgx_state_t st;
    pgx_tlb_entry_t [TLB_ENTRIES-1:0] tlb;
    logic [TLB_SETS-1:0][WAY_W-1:0] victim;
    logic [WAY_W-1:0] way;
    logic [LIN_W-1:0] lin;
    logic wr;
    logic user;
    logic [31:0] code_ptr;
    logic [31:0] entry;
    logic eff_us;
    logic eff_rw;
    logic [FRAME_W-1:0] dir_base;
    logic paging_en;
    logic [31:0] fault_addr;
    logic ready;
    logic done;
    logic [PHYS_W-1:0] phys;
    logic fault;
    logic [ERR_W-1:0] err;
    logic [31:0] saved_ptr;
    logic mem_req;
    logic mem_we;
    logic mem_lock;
    logic [PHYS_W-1:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [31:0] ctl_rdata;
  } pgx_regs_t;

  pgx_regs_t s;
  pgx_regs_t next_s;

  // entry address inside a 4 KB directory or table
  function automatic logic [PHYS_W-1:0] ent_addr(input logic [FRAME_W-1:0] base,
                                                 input logic [IDX_W-1:0] idx);
    ent_addr = {base, idx, 2'b00}; // [R7]
  endfunction

  // user-level rights check, supervisor bypasses
  function automatic logic violates(input logic user, input logic wr,
                                    input logic us, input logic rw);
    violates = user && (!us || (wr && !rw)); // [R14]
  endfunction

  function automatic logic [4:0] slot(input logic [SET_W-1:0] set, input logic [WAY_W-1:0] w);
    slot = {set, w};
  endfunction

  // frame or table base from an entry, cut to the 24-bit bus
  function automatic logic [FRAME_W-1:0] ent_base(input logic [31:0] e);
    ent_base = e[PHYS_W-1:PAGE_SHIFT]; // [R6] [R7] [R8]
  endfunction

  logic [SET_W-1:0] cur_set;
  logic [TAG_W-1:0] cur_tag;
  logic [TLB_WAYS-1:0] way_hit;
  logic [IDX_W-1:0] dir_idx;
  logic [IDX_W-1:0] tbl_idx;
  logic [PAGE_SHIFT-1:0] pg_off;

  assign cur_set = s.lin[PAGE_SHIFT+SET_W-1:PAGE_SHIFT];
  assign cur_tag = s.lin[LIN_W-1:PAGE_SHIFT+SET_W];
  assign dir_idx = s.lin[LIN_W-1:LIN_W-IDX_W]; // [R4]
  assign tbl_idx = s.lin[LIN_W-IDX_W-1:PAGE_SHIFT]; // [R5]
  assign pg_off = s.lin[PAGE_SHIFT-1:0]; // [R25]

  // tag compare across the four ways of the set
  genvar g;
  generate
    for (g = 0; g < TLB_WAYS; g++) begin : g_way
      assign way_hit[g] = s.tlb[slot(cur_set, WAY_W'(g))].valid &&
                          (s.tlb[slot(cur_set, WAY_W'(g))].tag == cur_tag); // [R17]
    end
  endgenerate

  always_comb begin
    logic f_go;
    logic f_prot;
    logic hit;
    logic [WAY_W-1:0] hit_way;
    pgx_tlb_entry_t he;
    logic t_us;
    logic t_rw;
    logic [31:0] upd;
    logic e_p;
    logic e_a;
    logic e_d;
    f_go = 1'b0;
    f_prot = 1'b0;
    hit = |way_hit;
    hit_way = '0;
    for (int w = 0; w < TLB_WAYS; w++) begin
      if (way_hit[w]) begin
        hit_way = WAY_W'(w);
      end
    end
    he = s.tlb[slot(cur_set, hit_way)];
    t_us = s.eff_us & mem_rdata[ENT_US]; // [R15]
    t_rw = s.eff_rw & mem_rdata[ENT_RW]; // [R15]
    upd = mem_rdata;
    e_p = mem_rdata[ENT_P]; // [R9]
    e_a = mem_rdata[ENT_A]; // [R9]
    e_d = mem_rdata[ENT_D]; // [R9]
    next_s = s;
    next_s.done = 1'b0;
    next_s.fault = 1'b0;

    // read data follows the select one cycle late
    case (ctl_sel)
      CTL_FAULT_ADDR: next_s.ctl_rdata = s.fault_addr;
      CTL_DIR_BASE: next_s.ctl_rdata = {8'h00, s.dir_base, 12'h000};
      CTL_MACHINE: next_s.ctl_rdata = {s.paging_en, 31'h0000_0000};
      default: next_s.ctl_rdata = 32'h0000_0000;
    endcase

    if (ctl_wr) begin
      case (ctl_sel)
        CTL_FAULT_ADDR: next_s.fault_addr = ctl_wdata;
        CTL_DIR_BASE: next_s.dir_base = ctl_wdata[PHYS_W-1:PAGE_SHIFT]; // [R2]
        CTL_MACHINE: next_s.paging_en = ctl_wdata[MCR_PG]; // [R23]
        default: next_s.paging_en = s.paging_en;
      endcase
    end

    case (s.st)
      PGX_IDLE: begin
        // ready is still low in the first cycle after reset
        if (req_valid && s.ready) begin
          next_s.lin = req_lin;
          next_s.wr = req_write;
          next_s.user = (req_cpl == USER_CPL) && !req_desc; // [R22]
          next_s.code_ptr = req_code_ptr;
          next_s.st = PGX_LOOK;
        end
      end
      PGX_LOOK: begin
        if (!s.paging_en) begin
          // paging off: linear address goes out cut to 24 bits
          next_s.phys = s.lin[PHYS_W-1:0]; // [R23]
          next_s.done = 1'b1;
          next_s.st = PGX_IDLE;
        end else if (hit && violates(s.user, s.wr, he.us, he.rw)) begin
          f_go = 1'b1; // [R19]
          f_prot = 1'b1;
        end else if (hit && !(s.wr && !he.dirty)) begin
          next_s.phys = {he.frame, pg_off}; // [R17] [R25]
          next_s.done = 1'b1;
          next_s.st = PGX_IDLE;
        end else begin
          // miss, or first write to a clean page: walk to set dirty
          next_s.way = hit ? hit_way : s.victim[cur_set];
          next_s.mem_req = 1'b1;
          next_s.mem_we = 1'b0;
          next_s.mem_lock = 1'b1; // [R13]
          next_s.mem_addr = ent_addr(s.dir_base, dir_idx); // [R4]
          next_s.st = PGX_DIR_RD; // [R18]
        end
      end
      PGX_DIR_RD: begin
        if (mem_ack) begin
          next_s.entry = mem_rdata;
          next_s.eff_us = mem_rdata[ENT_US];
          next_s.eff_rw = mem_rdata[ENT_RW];
          // other bits of a not-present entry are ignored
          if (!e_p) begin
            f_go = 1'b1; // [R10]
          end else if (!e_a) begin
            upd[ENT_A] = 1'b1; // [R11]
            next_s.mem_we = 1'b1;
            next_s.mem_wdata = upd;
            next_s.st = PGX_DIR_WR; // [R13]
          end else begin
            next_s.mem_addr = ent_addr(ent_base(mem_rdata), tbl_idx); // [R5] [R6]
            next_s.st = PGX_TBL_RD;
          end
        end
      end
      PGX_DIR_WR: begin
        if (mem_ack) begin
          next_s.mem_we = 1'b0;
          // accessed flag written back, lock kept for the table entry
          next_s.mem_addr = ent_addr(ent_base(s.entry), tbl_idx); // [R6]
          next_s.st = PGX_TBL_RD;
        end
      end
      PGX_TBL_RD: begin
        if (mem_ack) begin
          next_s.eff_us = t_us;
          next_s.eff_rw = t_rw;
          upd[ENT_A] = 1'b1; // [R11]
          upd[ENT_D] = e_d | s.wr; // [R12]
          next_s.entry = upd;
          // locked read ends without a write when flags are already set
          if (!e_p) begin
            f_go = 1'b1; // [R10]
          end else if (violates(s.user, s.wr, t_us, t_rw)) begin
            f_go = 1'b1; // [R19]
            f_prot = 1'b1;
          end else if (upd != mem_rdata) begin
            next_s.mem_we = 1'b1;
            next_s.mem_wdata = upd;
            next_s.st = PGX_TBL_WR; // [R13]
          end else begin
            next_s.mem_req = 1'b0;
            next_s.mem_lock = 1'b0;
            next_s.st = PGX_FILL;
          end
        end
      end
      PGX_TBL_WR: begin
        if (mem_ack) begin
          next_s.mem_req = 1'b0;
          next_s.mem_we = 1'b0;
          next_s.mem_lock = 1'b0;
          next_s.st = PGX_FILL;
        end
      end
      PGX_FILL: begin
        next_s.tlb[slot(cur_set, s.way)] = '{valid: 1'b1, tag: cur_tag,
                                            frame: ent_base(s.entry),
                                            us: s.eff_us, rw: s.eff_rw,
                                            dirty: s.entry[ENT_D]}; // [R16] [R18]
        // round-robin pointer moves only when its way was used
        if (s.way == s.victim[cur_set]) begin
          next_s.victim[cur_set] = s.victim[cur_set] + 2'h1;
        end
        next_s.phys = {ent_base(s.entry), pg_off}; // [R8] [R25]
        next_s.done = 1'b1;
        next_s.st = PGX_IDLE;
      end
      default: next_s.st = PGX_IDLE;
    endcase

    // after the fill, so a walk ending now leaves no stale entry
    if (ctl_wr && (ctl_sel == CTL_DIR_BASE)) begin
      for (int i = 0; i < TLB_ENTRIES; i++) begin
        next_s.tlb[i].valid = 1'b0; // [R3]
      end
    end

    // fault wins over a same-cycle control write of the fault address
    if (f_go) begin
      next_s.fault = 1'b1; // [R20]
      next_s.fault_addr = s.lin; // [R1]
      next_s.err = ERR_RST;
      next_s.err[ERR_P] = f_prot; // [R21] [R24]
      next_s.err[ERR_WR] = s.wr; // [R21] [R24]
      next_s.err[ERR_US] = s.user; // [R21] [R22] [R24]
      next_s.saved_ptr = s.code_ptr; // [R20]
      next_s.mem_req = 1'b0;
      next_s.mem_we = 1'b0;
      next_s.mem_lock = 1'b0;
      next_s.st = PGX_IDLE;
    end
    next_s.ready = (next_s.st == PGX_IDLE);
  end

  // whole state cleared by reset: paging off, cache invalid
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign req_ready = s.ready;
  assign xlat_done = s.done;
  assign xlat_phys = s.phys;
  assign page_fault = s.fault;
  assign fault_error_code = s.err;
  assign saved_code_pointer = s.saved_ptr;
  assign ctl_rdata = s.ctl_rdata;
  assign mem_req = s.mem_req;
  assign mem_we = s.mem_we;
  assign mem_lock = s.mem_lock;
  assign mem_addr = s.mem_addr;
  assign mem_wdata = s.mem_wdata;
endmodule

`default_nettype wire

// File: pgx_mem_model.sv
// memory model holding the page tables
`timescale 1ns/1ps
`default_nettype none
module pgx_mem_model (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [31:0] m [int];
  int wait_n = 0;
  initial mem_rdata = 32'h0000_0000;
  initial mem_ack = 1'b0;
  always @(posedge clk_sys) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata; // no stale data outside an answer
    if (mem_req && !mem_ack) begin
      if (wait_n < (slow ? 3 : 0)) begin
        wait_n <= wait_n + 1;
      end else begin
        wait_n <= 0;
        mem_ack <= 1'b1;
        if (mem_we) begin
          m[int'(mem_addr[23:2])] = mem_wdata;
        end else begin
          mem_rdata <= m.exists(int'(mem_addr[23:2])) ? m[int'(mem_addr[23:2])] : 32'h0000_0000;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: pgx_chk.sv
// assertions on the paging unit ports
`timescale 1ns/1ps
`default_nettype none
module pgx_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [31:0] req_lin,
  input wire logic req_write,
  input wire logic [1:0] req_cpl,
  input wire logic req_desc,
  input wire logic xlat_done,
  input wire logic [23:0] xlat_phys,
  input wire logic page_fault,
  input wire logic [15:0] fault_error_code,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_lock,
  input wire logic [23:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack
);
  import pgx_pkg::*;
  logic [31:0] lin_q;
  logic wr_q;
  logic usr_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lin_q <= 32'h0000_0000;
      wr_q <= 1'b0;
      usr_q <= 1'b0;
    end else if (req_valid && req_ready) begin
      lin_q <= req_lin;
      wr_q <= req_write;
      usr_q <= (req_cpl == USER_CPL) && !req_desc;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_low; xlat_done |-> xlat_phys[11:0] == lin_q[11:0]; endproperty
  a_low: assert property (p_low) else $error("low bits altered");
  property p_errhi; page_fault |-> fault_error_code[15:3] == 13'h0000; endproperty
  a_errhi: assert property (p_errhi) else $error("code high bits");
  property p_errwr; page_fault |-> fault_error_code[ERR_WR] == wr_q; endproperty
  a_errwr: assert property (p_errwr) else $error("code write bit");
  property p_errus; page_fault |-> fault_error_code[ERR_US] == usr_q; endproperty
  a_errus: assert property (p_errus) else $error("code user bit");
  property p_dir; $rose(mem_req) |-> !mem_we && mem_addr[11:0] == {lin_q[31:22], 2'b00}; endproperty
  a_dir: assert property (p_dir) else $error("directory index");
  property p_tbl; mem_req && !mem_we && $past(mem_ack) |-> mem_addr[11:0] == {lin_q[21:12], 2'b00};
  endproperty
  a_tbl: assert property (p_tbl) else $error("table index");
  property p_rmw; mem_req && mem_we |-> mem_lock && mem_addr == $past(mem_addr); endproperty
  a_rmw: assert property (p_rmw) else $error("unlocked update");
  property p_acc; mem_req && mem_we |-> mem_wdata[ENT_A] && mem_wdata[ENT_P]; endproperty
  a_acc: assert property (p_acc) else $error("accessed not set");
  property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
  a_hold: assert property (p_hold) else $error("access dropped");
  property p_busy; mem_req |-> !req_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready during walk");
  c_done: cover property (xlat_done);
  c_fault: cover property (page_fault);
  c_upd: cover property (mem_req && mem_we && mem_ack);
endmodule
bind pgx_paging_unit pgx_chk pgx_chk_inst (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
  .req_ready(req_ready), .req_lin(req_lin), .req_write(req_write), .req_cpl(req_cpl),
  .req_desc(req_desc), .xlat_done(xlat_done), .xlat_phys(xlat_phys), .page_fault(page_fault),
  .fault_error_code(fault_error_code), .mem_req(mem_req), .mem_we(mem_we), .mem_lock(mem_lock),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack));
`default_nettype wire

// File: two_level_page_translation_bench.sv
// self-checking bench for the paging unit
`timescale 1ns/1ps
`default_nettype none
module two_level_page_translation_bench;
  import pgx_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, req_desc = 1'b0, ctl_wr = 1'b0, slow = 1'b0;
  logic [1:0] req_cpl = 2'h0, ctl_sel = 2'h3;
  logic [31:0] req_lin = 32'h0000_0000, req_code_ptr = 32'h0000_0000, ctl_wdata = 32'h0000_0000;
  logic req_ready, xlat_done, page_fault, mem_req, mem_we, mem_lock, mem_ack;
  logic [23:0] xlat_phys, mem_addr;
  logic [15:0] fault_error_code;
  logic [31:0] saved_code_pointer, ctl_rdata, mem_wdata, mem_rdata;
  int err_total = 0, n_tests = 0, n_acc = 0, lat, n;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (mem_req && mem_ack) n_acc <= n_acc + 1;
  pgx_paging_unit pgx_paging_unit_inst (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req_lin(req_lin), .req_write(req_write), .req_cpl(req_cpl), .req_desc(req_desc),
    .req_code_ptr(req_code_ptr), .req_ready(req_ready), .xlat_done(xlat_done),
    .xlat_phys(xlat_phys), .page_fault(page_fault), .fault_error_code(fault_error_code),
    .saved_code_pointer(saved_code_pointer), .ctl_wr(ctl_wr), .ctl_sel(ctl_sel),
    .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_lock(mem_lock), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  pgx_mem_model pgx_mem_model_inst (.clk_sys(clk_sys), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ctl(input logic [1:0] s, input logic [31:0] d, input logic w);
    @(posedge clk_sys);
    ctl_wr <= w;
    ctl_sel <= s;
    ctl_wdata <= d;
    @(posedge clk_sys);
    ctl_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic xl(input logic [31:0] a, input logic w, input logic [1:0] c, input logic d);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_lin <= a;
    req_write <= w;
    req_cpl <= c;
    req_desc <= d;
    req_code_ptr <= ~a;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    lat = 0;
    do begin
      @(posedge clk_sys);
      lat++;
      if (lat > 200) begin
        err_total++;
        results();
      end
    end while (xlat_done !== 1'b1 && page_fault !== 1'b1);
  endtask
  task automatic t_reset();
    chk(req_ready, 1'b1);
    ctl(CTL_DIR_BASE, 32'h0000_0000, 1'b0);
    chk(ctl_rdata, 32'h0000_0000);
    ctl(CTL_MACHINE, 32'h0000_0000, 1'b0);
    chk(ctl_rdata, 32'h0000_0000);
    xl(32'h1234_5678, 1'b0, 2'h3, 1'b0);
    chk(xlat_phys, 32'h0034_5678);
    chk(lat, 2);
    $display("reset and direct mapping finished");
  endtask
  task automatic t_walk();
    pgx_mem_model_inst.m['h401] = 32'h0000_2007;
    pgx_mem_model_inst.m['h803] = 32'hFF05_6007;
    ctl(CTL_DIR_BASE, 32'hFF00_1FFF, 1'b1);
    chk(ctl_rdata, 32'h0000_1000);
    ctl(CTL_MACHINE, 32'h8000_0000, 1'b1);
    xl(32'h0040_3ABC, 1'b0, 2'h3, 1'b0);
    chk(xlat_phys, 32'h0005_6ABC);
    chk(pgx_mem_model_inst.m['h401], 32'h0000_2027);
    chk(pgx_mem_model_inst.m['h803], 32'hFF05_6027);
    n = n_acc;
    xl(32'h0040_3123, 1'b0, 2'h3, 1'b0);
    chk(n_acc - n, 0);
    chk(lat, 2);
    xl(32'h0040_3ABC, 1'b1, 2'h3, 1'b0);
    chk(pgx_mem_model_inst.m['h803], 32'hFF05_6067);
    ctl(CTL_DIR_BASE, 32'h0000_1000, 1'b1);
    n = n_acc;
    xl(32'h0040_3ABC, 1'b0, 2'h3, 1'b0);
    chk(n_acc - n, 2);
    $display("walk and cache finished");
  endtask
  task automatic t_fault();
    slow <= 1'b1;
    xl(32'h0040_5123, 1'b0, 2'h3, 1'b0);
    chk(page_fault, 1'b1);
    chk(fault_error_code, 16'h0004);
    chk(saved_code_pointer, 32'hFFBF_AEDC);
    ctl(CTL_FAULT_ADDR, 32'h0000_0000, 1'b0);
    chk(ctl_rdata, 32'h0040_5123);
    xl(32'h0080_0123, 1'b1, 2'h3, 1'b1);
    chk(fault_error_code, 16'h0002);
    slow <= 1'b0;
    $display("not-present faults finished");
  endtask
  task automatic t_prot();
    pgx_mem_model_inst.m['h804] = 32'h0007_7005;
    pgx_mem_model_inst.m['h403] = 32'h0000_3003;
    pgx_mem_model_inst.m['hC00] = 32'h0008_8007;
    xl(32'h0040_4010, 1'b1, 2'h3, 1'b0);
    chk(fault_error_code, 16'h0007);
    xl(32'h0040_4010, 1'b1, 2'h0, 1'b0);
    chk(xlat_phys, 32'h0007_7010);
    xl(32'h00C0_0020, 1'b0, 2'h3, 1'b0);
    chk(fault_error_code, 16'h0005);
    $display("protection finished");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_walk();
    t_fault();
    t_prot();
    results();
  end
endmodule
`default_nettype wire
